// File: rtl/pin_sync.sv
// Two-flop synchroniser with rising edge detect for an asynchronous pin.
// Assumes the pin changes slower than half the bus clock.
`timescale 1ns/10ps
module pin_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   output logic level,
   output logic rise
);
   typedef struct packed {
      logic meta;
      logic stable;
      logic prev;
      logic [2:0] fill;
   } sync_state_t;

   sync_state_t q;
   sync_state_t d;

   always_comb begin
      d = q;
      d.meta = pin;
      d.stable = q.meta;
      d.prev = q.stable;
      d.fill = {q.fill[1:0], 1'b1};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level = q.stable;
   // No edge until prev holds a real sample; a pin high at reset fakes none
   assign rise = q.stable & ~q.prev & q.fill[2];
endmodule

// File: rtl/tick_counter.sv
// Wrapping tick counter: counts ticks, pulses done at the terminal count, restarts from zero.
// Assumes terminal is at least one; clear wins over a tick.
`timescale 1ns/10ps
module tick_counter
   import wdt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic tick,
   input wire logic [wdt_pkg::CNT_W-1:0] terminal,
   output logic done
);
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic done;
   } cnt_state_t;

   cnt_state_t q;
   cnt_state_t d;

   always_comb begin
      d = q;
      d.done = 1'b0;
      if (clear) begin
         d.count = '0;
      end else if (tick) begin
         if (q.count == terminal - 13'h0001) begin
            d.count = '0;
            d.done = 1'b1;
         end else begin
            d.count = q.count + 13'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;
endmodule

// File: rtl/wdt_por_top.sv
// Watchdog and power-on timer with an AXI4-Lite register slave.
// Assumes a 50 MHz aclk; RC, crystal, recovery and supply pins are asynchronous.
// Operation
// - Retriggerable one-shot; terminal count resets chip
// - Timeout in run or halt equals power-on reset
// - First refresh enables, later refreshes restart count
// - Enabled watchdog cannot be disabled by software
// - Permanent option runs from reset; refresh restarts
// - Refresh updates zero, sign, overflow flags
// - Mode writable 64 cycles after start, then locked
// - Mode register write-only at index 0fh
// - Two time-select bits pick the timeout tap
// - Time select resets to second-shortest tap
// - Bit 2 keeps counting in halt
// - Bit 3 keeps counting in stop
// - Bits 3 and 4 give crystal-clocked stop wake
// - Stop timeout recovers without full register reset
// - Bit 4 picks crystal, default RC source
// - Mode bits 7 to 5 are reserved
// - Power-on timer triggered by cold, stop, timeout
// - Execution held until power-on interval expires
// - Global reset held while supply is low
// - Recovery bit 5 clear bypasses power-on timer
// - Cold start resets registers, clears warm flag
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
module wdt_por_top
   import wdt_pkg::*;
#(
   parameter bit PERMANENT_ON = 1'b0,
   parameter logic [12:0] POR_TICKS = 13'h0100
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [wdt_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [wdt_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic rc_osc_pin,
   input wire logic crystal_input_pin,
   input wire logic stop_recovery_src,
   input wire logic supply_low,
   input wire logic cpu_halt,
   input wire logic cpu_stop,
   output logic chip_reset,
   output logic exec_hold,
   output logic stop_exit,
   output logic flags_update,
   output logic [2:0] flags_zsv
);
   import wdt_pkg::*;

   typedef struct packed {
      phase_t phase;
      logic [MODE_W-1:0] mode;
      logic [6:0] window;
      logic mode_locked;
      logic wdt_enabled;
      logic smr_delay;
      logic warm_start;
      logic wdt_reset_seen;
      logic stop_exit;
      logic flags_update;
      logic [2:0] flags_zsv;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic chip_reset;
      logic exec_hold;
   } top_state_t;

   localparam top_state_t STATE_RESET = '{
      phase: PH_COLD,
      mode: MODE_RESET,
      window: '0,
      mode_locked: 1'b0,
      wdt_enabled: 1'b0,
      smr_delay: SMR_DELAY_RESET,
      warm_start: 1'b0,
      wdt_reset_seen: 1'b0,
      stop_exit: 1'b0,
      flags_update: 1'b0,
      flags_zsv: '0,
      awready: 1'b0,
      wready: 1'b0,
      bvalid: 1'b0,
      bresp: RESP_OKAY,
      arready: 1'b0,
      rvalid: 1'b0,
      rresp: RESP_OKAY,
      rdata: '0,
      chip_reset: 1'b1,
      exec_hold: 1'b1
   };

   top_state_t q;
   top_state_t d;

   logic rc_rise;
   logic xtal_rise;
   logic rec_level;
   logic rec_rise;
   logic low_level;

   pin_sync u_rc_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(rc_osc_pin),
      .level(),
      .rise(rc_rise)
   );

   pin_sync u_xtal_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(crystal_input_pin),
      .level(),
      .rise(xtal_rise)
   );

   pin_sync u_rec_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(stop_recovery_src),
      .level(rec_level),
      .rise(rec_rise)
   );

   pin_sync u_low_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(supply_low),
      .level(low_level),
      .rise()
   );

   logic running;
   logic wr_fire;
   logic [5:0] wr_idx;
   logic refresh_now;
   logic wdt_active;
   logic src_tick;
   logic mode_allows;
   logic wdt_tick;
   logic wdt_clear;
   logic wdt_timeout;
   logic [CNT_W-1:0] tap_terminal;
   logic por_clear;
   logic por_done;
   logic hold_clear;
   logic hold_done;

   assign running = (q.phase == PH_RUN);
   assign wr_fire = q.awready & awvalid & wvalid;
   assign wr_idx = awaddr[ADDR_W-1:2];
   assign refresh_now = wr_fire & (wr_idx == REFRESH_IDX) & running;

   assign wdt_active = (q.wdt_enabled | PERMANENT_ON) & running;
   // Source pick also applies in stop, giving the crystal-driven wake
   assign src_tick = q.mode[MODE_SRC_BIT] ? xtal_rise : rc_rise;
   always_comb begin
      if (cpu_stop) begin
         mode_allows = q.mode[MODE_STOP_BIT];
      end else if (cpu_halt) begin
         mode_allows = q.mode[MODE_HALT_BIT];
      end else begin
         mode_allows = 1'b1;
      end
   end
   assign wdt_tick = wdt_active & src_tick & mode_allows;
   assign wdt_clear = ~running | refresh_now;

   always_comb begin
      unique case (q.mode[MODE_TAP_LSB +: 2])
         2'b00: tap_terminal = TAP_256;
         2'b01: tap_terminal = TAP_512;
         2'b10: tap_terminal = TAP_1024;
         2'b11: tap_terminal = TAP_4096;
      endcase
   end

   tick_counter u_wdt_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(wdt_clear),
      .tick(wdt_tick),
      .terminal(tap_terminal),
      .done(wdt_timeout)
   );

   // Power-on timer runs on the RC oscillator only
   assign por_clear = running | low_level;
   tick_counter u_por_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(por_clear),
      .tick(rc_rise),
      .terminal(POR_TICKS),
      .done(por_done)
   );

   // Bypassed recovery must see the source held for five crystal periods
   assign hold_clear = ~rec_level | ~cpu_stop | ~running;
   tick_counter u_hold_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(hold_clear),
      .tick(xtal_rise),
      .terminal(STOP_HOLD_TICKS),
      .done(hold_done)
   );

   logic stop_recover;
   logic ext_recover;

   assign ext_recover = q.smr_delay ? rec_rise : hold_done;
   assign stop_recover = cpu_stop & running & (wdt_timeout | ext_recover);

   always_comb begin
      d = q;
      d.stop_exit = 1'b0;
      d.flags_update = 1'b0;

      // Write channel: address and data taken together, one at a time
      d.awready = ~q.awready & ~q.bvalid & awvalid & wvalid;
      d.wready = ~q.awready & ~q.bvalid & awvalid & wvalid;
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      if (wr_fire) begin
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         unique case (wr_idx)
            MODE_IDX: begin
               // Late writes are dropped silently, still answered OKAY
               if (wstrb[0] && !q.mode_locked && running) begin
                  d.mode = wdata[MODE_W-1:0];
               end
            end
            SMR_IDX: begin
               if (wstrb[0]) begin
                  d.smr_delay = wdata[SMR_DELAY_BIT];
               end
            end
            REFRESH_IDX: begin
               if (running) begin
                  d.wdt_enabled = 1'b1;
                  d.flags_update = 1'b1;
                  d.flags_zsv = FLAGS_AFTER_REFRESH;
               end
            end
            STATUS_IDX: begin
               d.bresp = RESP_OKAY;
            end
            default: begin
               d.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Read channel
      d.arready = ~q.arready & ~q.rvalid & arvalid;
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (q.arready && arvalid) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = '0;
         unique case (araddr[ADDR_W-1:2])
            MODE_IDX: d.rdata = '0;
            REFRESH_IDX: d.rdata = '0;
            SMR_IDX: begin
               d.rdata[SMR_WARM_BIT] = q.warm_start;
               d.rdata[SMR_DELAY_BIT] = q.smr_delay;
            end
            STATUS_IDX: begin
               d.rdata[ST_ENABLED_BIT] = q.wdt_enabled | PERMANENT_ON;
               d.rdata[ST_LOCKED_BIT] = q.mode_locked;
               d.rdata[ST_HOLD_BIT] = q.exec_hold;
               d.rdata[ST_WDT_RESET_BIT] = q.wdt_reset_seen;
            end
            default: d.rresp = RESP_SLVERR;
         endcase
      end

      // Write window opens at the first instruction after each start
      if (!running) begin
         d.window = '0;
         d.mode_locked = 1'b0;
      end else if (!q.mode_locked) begin
         if (q.window == MODE_WINDOW_CYCLES - 7'h01) begin
            d.mode_locked = 1'b1;
         end else begin
            d.window = q.window + 7'h01;
         end
      end

      if (por_done) begin
         if (q.phase == PH_WARM) begin
            d.stop_exit = 1'b1;
         end
         d.phase = PH_RUN;
      end

      if (wdt_timeout && !cpu_stop && running) begin
         d.phase = PH_COLD;
         d.wdt_reset_seen = 1'b1;
      end

      // Stop recovery leaves control registers alone
      if (stop_recover) begin
         d.warm_start = 1'b1;
         if (q.smr_delay) begin
            d.phase = PH_WARM;
         end else begin
            d.stop_exit = 1'b1;
            d.window = '0;
            d.mode_locked = 1'b0;
         end
      end

      // A low supply is treated as a fresh cold start and wins over all
      if (low_level) begin
         d.phase = PH_COLD;
         d.warm_start = 1'b0;
         d.wdt_reset_seen = 1'b0;
      end

      // Global reset returns control state to defaults
      if (d.phase == PH_COLD) begin
         d.mode = MODE_RESET;
         d.smr_delay = SMR_DELAY_RESET;
         d.wdt_enabled = 1'b0;
      end

      d.chip_reset = (d.phase == PH_COLD);
      d.exec_hold = (d.phase != PH_RUN);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= STATE_RESET;
      end else begin
         q <= d;
      end
   end

   assign awready = q.awready;
   assign wready = q.wready;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = q.arready;
   assign rvalid = q.rvalid;
   assign rresp = q.rresp;
   assign rdata = q.rdata;
   assign chip_reset = q.chip_reset;
   assign exec_hold = q.exec_hold;
   assign stop_exit = q.stop_exit;
   assign flags_update = q.flags_update;
   assign flags_zsv = q.flags_zsv;
endmodule

// File: shared/wdt_pkg.sv
// Constants, register map and state types of the watchdog and power-on timer.
// Assumes a 50 MHz bus clock and external oscillator pins sampled in that domain.
package wdt_pkg;

   localparam int unsigned CLK_PERIOD_NS = 20;

   // Register indices; byte address is the index times four
   localparam int unsigned ADDR_W = 8;
   localparam logic [5:0] SMR_IDX = 6'h0b;
   localparam logic [5:0] MODE_IDX = 6'h0f;
   localparam logic [5:0] REFRESH_IDX = 6'h10;
   localparam logic [5:0] STATUS_IDX = 6'h11;

   // Watchdog mode control fields
   localparam int unsigned MODE_W = 5;
   localparam int unsigned MODE_TAP_LSB = 0;
   localparam int unsigned MODE_HALT_BIT = 2;
   localparam int unsigned MODE_STOP_BIT = 3;
   localparam int unsigned MODE_SRC_BIT = 4;
   localparam logic [4:0] MODE_RESET = 5'h0d;

   // Stop recovery control fields
   localparam int unsigned SMR_DELAY_BIT = 5;
   localparam int unsigned SMR_WARM_BIT = 7;
   localparam logic SMR_DELAY_RESET = 1'b1;

   // Status fields
   localparam int unsigned ST_ENABLED_BIT = 0;
   localparam int unsigned ST_LOCKED_BIT = 1;
   localparam int unsigned ST_HOLD_BIT = 2;
   localparam int unsigned ST_WDT_RESET_BIT = 3;

   // Counter chain and tap terminal counts, in source clock periods
   localparam int unsigned CNT_W = 13;
   localparam logic [12:0] TAP_256 = 13'h0100;
   localparam logic [12:0] TAP_512 = 13'h0200;
   localparam logic [12:0] TAP_1024 = 13'h0400;
   localparam logic [12:0] TAP_4096 = 13'h1000;
   localparam logic [12:0] STOP_HOLD_TICKS = 13'h0005;

   localparam logic [6:0] MODE_WINDOW_CYCLES = 7'h40;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Zero, sign, overflow as left by a refresh
   localparam logic [2:0] FLAGS_AFTER_REFRESH = 3'h4;

   typedef enum logic [1:0] {
      PH_COLD = 2'b00,
      PH_WARM = 2'b01,
      PH_RUN = 2'b10
   } phase_t;

endpackage

// File: tb/core_model.sv
// Core-side model: keeps refresh flags, raises stop recovery on request.
// Assumes the crystal pin toggles slower than half of aclk.
`timescale 1ns/10ps
module core_model (
   input wire logic aclk,
   input wire logic crystal_input_pin,
   input wire logic wake_req,
   input wire logic flags_update,
   input wire logic [2:0] flags_zsv,
   output logic stop_recovery_src,
   output logic [2:0] flag_reg
);
   logic xtal_q = 1'b0;
   int rises = 0;
   initial begin
      stop_recovery_src = 1'b0;
      flag_reg = 3'h0;
   end
   always @(posedge aclk) begin
      xtal_q <= crystal_input_pin;
      if (flags_update) begin
         flag_reg <= flags_zsv;
      end
      if (wake_req) begin
         stop_recovery_src <= 1'b1;
         rises <= 0;
      end else if (stop_recovery_src && crystal_input_pin && !xtal_q) begin
         // Eight periods, margin over five for pin sync
         if (rises == 7) stop_recovery_src <= 1'b0;
         rises <= rises + 1;
      end
   end
endmodule

// File: tb/testbench.sv
// Self-checking bench of the watchdog and power-on timer.
// Assumes wdt_pkg, wdt_por_top, core_model and the checker compiled first.
`timescale 1ns/10ps
module testbench;
   import wdt_pkg::*;
   localparam int RC_CYC = 7;
   localparam int XT_CYC = 5;
   localparam int POR = 4;
   localparam logic [7:0] A_SMR = {SMR_IDX, 2'b00};
   localparam logic [7:0] A_MODE = {MODE_IDX, 2'b00};
   localparam logic [7:0] A_REFR = {REFRESH_IDX, 2'b00};
   localparam logic [7:0] A_STAT = {STATUS_IDX, 2'b00};
   typedef struct {
      bit w;
      logic [7:0] a;
      logic [1:0] r;
      logic [31:0] q;
   } row_t;
   logic aclk = 1'b0, aresetn = 1'b0, rc_osc_pin = 1'b0, crystal_input_pin = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic supply_low = 1'b0, cpu_stop = 1'b0, wake_req = 1'b0, cpu_halt = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, chip_reset, exec_hold, stop_exit;
   logic flags_update, stop_recovery_src;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, q;
   logic [2:0] flags_zsv, flag_reg;
   int bad_count = 0, cmp_count = 0, cycles = 0, n, m;
   row_t rows[6] = '{'{1'b0, A_STAT, RESP_OKAY, 32'h0}, '{1'b0, A_MODE, RESP_OKAY, 32'h0},
      '{1'b0, A_SMR, RESP_OKAY, 32'h20}, '{1'b0, A_REFR, RESP_OKAY, 32'h0},
      '{1'b0, 8'h48, RESP_SLVERR, 32'h0}, '{1'b1, 8'h48, RESP_SLVERR, 32'h0}};

   wdt_por_top #(.PERMANENT_ON(1'b0), .POR_TICKS(13'h0004)) dut_u (.aclk(aclk),
      .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .rc_osc_pin(rc_osc_pin), .crystal_input_pin(crystal_input_pin),
      .stop_recovery_src(stop_recovery_src), .supply_low(supply_low), .cpu_halt(cpu_halt),
      .cpu_stop(cpu_stop), .chip_reset(chip_reset), .exec_hold(exec_hold),
      .stop_exit(stop_exit), .flags_update(flags_update), .flags_zsv(flags_zsv));
   core_model core_u (.aclk(aclk), .crystal_input_pin(crystal_input_pin),
      .wake_req(wake_req), .flags_update(flags_update), .flags_zsv(flags_zsv),
      .stop_recovery_src(stop_recovery_src), .flag_reg(flag_reg));

   always #10 aclk = ~aclk;
   // Pins start 3 ns off the grid so no pin edge meets an aclk edge
   initial begin
      #3;
      forever #70 rc_osc_pin = ~rc_osc_pin;
   end
   initial begin
      #3;
      forever #50 crystal_input_pin = ~crystal_input_pin;
   end

   task automatic tally_and_finish;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         bad_count++;
         tally_and_finish;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc;
      @(posedge aclk);
      #1;
   endtask

   task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      arvalid <= !w;
      bready <= w;
      rready <= !w;
      // Each channel drops its valid at the edge that takes it
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(bvalid && bready) && !(rvalid && rready));
      resp = w ? bresp : rresp;
      q = rdata;
      bready <= 1'b0;
      rready <= 1'b0;
      #1;
   endtask

   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      #1;
      chk({chip_reset, exec_hold}, 2'b11);
      @(posedge aclk);
      aresetn <= 1'b1;
      n = 0;
      #1;
      while (exec_hold !== 1'b0) begin
         cyc();
         n++;
      end
      chk(n >= (POR - 1) * RC_CYC && n <= POR * RC_CYC + 10, 1);
   endtask

   task automatic time_out(input int exp, input int per);
      n = 0;
      while (chip_reset !== 1'b1 && n < 2 * exp) begin
         cyc();
         n++;
      end
      chk(n + per >= exp && n <= exp + per + 6, 1);
      while (exec_hold !== 1'b0) cyc();
   endtask

   task automatic stop_case(input logic [31:0] stop_recovery_control, input bit hold_exp);
      axi(1'b1, A_SMR, stop_recovery_control);
      @(posedge aclk);
      cpu_stop <= 1'b1;
      wake_req <= 1'b1;
      @(posedge aclk);
      wake_req <= 1'b0;
      n = 0;
      m = 0;
      #1;
      while (stop_exit !== 1'b1 && n < 200) begin
         if (exec_hold !== 1'b0) m[0] = 1'b1;
         if (chip_reset !== 1'b0) m[1] = 1'b1;
         cyc();
         n++;
      end
      chk({stop_exit, m[1:0]}, {1'b1, 1'b0, hold_exp});
      chk(n >= 4 * XT_CYC, 1);
      @(posedge aclk);
      cpu_stop <= 1'b0;
      axi(1'b0, A_SMR, 32'h0);
      chk(q, 32'h80 | stop_recovery_control);
   endtask

   initial begin
      do_reset();
      foreach (rows[i]) begin
         axi(rows[i].w, rows[i].a, 32'hff);
         chk(resp, rows[i].r);
         if (!rows[i].w) chk(q, rows[i].q);
      end
      $display("Test reset and map done");
      repeat (70) @(posedge aclk);
      axi(1'b1, A_MODE, 32'hfc);
      axi(1'b1, A_REFR, 32'h0);
      chk(flag_reg, 32'h4);
      time_out(512 * RC_CYC, RC_CYC);
      $display("Test locked mode done");
      axi(1'b0, A_STAT, 32'h0);
      chk(q, 32'h8);
      axi(1'b1, A_MODE, 32'hf8);
      axi(1'b1, A_REFR, 32'h0);
      // Halt outlasts the tap, so a counting watchdog would reset the chip
      @(posedge aclk);
      cpu_halt <= 1'b1;
      repeat (1400) @(posedge aclk);
      cpu_halt <= 1'b0;
      #1;
      chk(chip_reset, 1'b0);
      axi(1'b1, A_STAT, 32'h0);
      axi(1'b0, A_STAT, 32'h0);
      chk(q, 32'hb);
      axi(1'b1, A_REFR, 32'h0);
      time_out(256 * XT_CYC, XT_CYC);
      $display("Test crystal tap done");
      stop_case(32'h20, 1'b1);
      stop_case(32'h0, 1'b0);
      $display("Test stop recovery done");
      @(posedge aclk);
      supply_low <= 1'b1;
      repeat (20) @(posedge aclk);
      #1;
      chk(chip_reset, 1);
      @(posedge aclk);
      supply_low <= 1'b0;
      #1;
      while (exec_hold !== 1'b0) cyc();
      axi(1'b0, A_SMR, 32'h0);
      chk(q, 32'h20);
      $display("Test supply low done");
      do_reset();
      $display("Test second reset done");
      tally_and_finish;
   end
endmodule

// File: tb/wdt_por_sva.sv
// Port checker for the watchdog and power-on timer.
// Assumes it is bound onto wdt_por_top and sees only its ports.
`timescale 1ns/10ps
module wdt_por_sva
   import wdt_pkg::*;
#(
   parameter logic [12:0] POR_TICKS = 13'h0100
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic supply_low,
   input wire logic chip_reset,
   input wire logic exec_hold,
   input wire logic stop_exit,
   input wire logic flags_update,
   input wire logic [2:0] flags_zsv
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      awvalid && wvalid && awready && wready;
   endsequence
   sequence s_refresh_seen;
      flags_update && flags_zsv == FLAGS_AFTER_REFRESH && bvalid;
   endsequence
   property p_cold;
      $rose(aresetn) |-> chip_reset && exec_hold;
   endproperty
   property p_hold;
      chip_reset |-> exec_hold;
   endproperty
   property p_release;
      $fell(chip_reset) |-> $fell(exec_hold);
   endproperty
   property p_supply;
      supply_low [*6] |-> chip_reset;
   endproperty
   property p_flags;
      flags_update |-> s_refresh_seen ##1 !flags_update;
   endproperty
   property p_bresp;
      s_wr_taken |=> bvalid ##0 !awready;
   endproperty
   property p_rresp;
      arvalid && arready |=> rvalid && !arready;
   endproperty
   property p_bhold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   property p_stop;
      stop_exit |-> !chip_reset ##1 !stop_exit;
   endproperty
   a_cold: assert property (p_cold) else $error("chip not held after reset");
   a_hold: assert property (p_hold) else $error("execution runs in reset");
   a_release: assert property (p_release) else $error("hold and reset apart");
   a_supply: assert property (p_supply) else $error("supply low without reset");
   a_flags: assert property (p_flags) else $error("refresh flags wrong");
   a_bresp: assert property (p_bresp) else $error("write answer late");
   a_rresp: assert property (p_rresp) else $error("read answer late");
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   a_stop: assert property (p_stop) else $error("stop exit malformed");
endmodule

bind wdt_por_top wdt_por_sva #(.POR_TICKS(POR_TICKS)) sva_u (.aclk, .aresetn, .awvalid,
   .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rvalid,
   .supply_low, .chip_reset, .exec_hold, .stop_exit, .flags_update, .flags_zsv);
